// file: verilog/ddimc_defines.vh
`ifndef DDIMC_DEFINES_VH
`define DDIMC_DEFINES_VH

// ************************************************************
// Control word field positions
// ************************************************************
`define DDIMC_CW_POWER_DOWN_BIT   7
`define DDIMC_CW_CONV_ENABLE_BIT  6
`define DDIMC_CW_SECOND_FILT_BIT  5
`define DDIMC_CW_FIRST_FILT_BIT   4
`define DDIMC_CW_GAIN_MSB         3
`define DDIMC_CW_GAIN_LSB         0

// ************************************************************
// Reset values
// ************************************************************
// No interpolation, 0 dB trim, converter running
`define DDIMC_CW_RESET            8'h40
`define DDIMC_GAIN_RESET          4'h0

// ************************************************************
// Interpolation mode codes
// ************************************************************
`define DDIMC_MODE_1X             2'h0
`define DDIMC_MODE_2X             2'h1
`define DDIMC_MODE_4X             2'h2

// ************************************************************
// Gain trim
// ************************************************************
// Step is 0.05 dB; the top code gives the +0.4 dB end
`define DDIMC_GAIN_TOP_CODE       4'h8
`define DDIMC_GAIN_TOP_STEPS      5'h08

// ************************************************************
// Timing counts, in CLK cycles, except LOCK_EDGES in reference edges
// ************************************************************
`define DDIMC_CLK_HALF_DIV        2
`define DDIMC_LOCK_EDGES          16
`define DDIMC_LOCK_TIMEOUT        64

`endif

// file: verilog/ddimc_lock_det.v
`include "ddimc_defines.vh"

module ddimc_lock_det #(
    parameter EDGES   = `DDIMC_LOCK_EDGES,
    parameter TIMEOUT = `DDIMC_LOCK_TIMEOUT
) (
    // Clock and reset
    input  wire        clk,
    input  wire        rst,
    // Observed reference
    input  wire        enable,
    input  wire        ref_edge,
    // Status
    output reg         locked_q
);

    reg  [7:0] edge_cnt_q;
    reg  [7:0] gap_cnt_q;

    // ************************************************************
    // Lock when enough edges arrive each within the timeout
    // ************************************************************
    // A disabled loop drops lock at once; a stopped reference drops it after TIMEOUT cycles without an edge
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            edge_cnt_q <= 8'h00;
            gap_cnt_q  <= 8'h00;
            locked_q   <= 1'b0;
        end else if (!enable) begin
            edge_cnt_q <= 8'h00;
            gap_cnt_q  <= 8'h00;
            locked_q   <= 1'b0;
        end else if (ref_edge) begin
            gap_cnt_q <= 8'h00;
            if (edge_cnt_q == EDGES[7:0] - 8'h01) begin
                locked_q <= 1'b1;
            end else begin
                edge_cnt_q <= edge_cnt_q + 8'h01;
            end
        end else if (gap_cnt_q == TIMEOUT[7:0] - 8'h01) begin
            gap_cnt_q  <= 8'h00;
            edge_cnt_q <= 8'h00;
            locked_q   <= 1'b0;
        end else begin
            gap_cnt_q <= gap_cnt_q + 8'h01;
        end
    end

endmodule // ddimc_lock_det

// file: verilog/ddimc_top.v
`include "ddimc_defines.vh"

module ddimc_top #(
    parameter HALF_DIV     = `DDIMC_CLK_HALF_DIV,
    parameter LOCK_EDGES   = `DDIMC_LOCK_EDGES,
    parameter LOCK_TIMEOUT = `DDIMC_LOCK_TIMEOUT
) (
    // Clock and reset
    input  wire        CLK,
    input  wire        RST,
    // Sample and control ports
    input  wire [7:0]  FIRST_CHANNEL_PORT,
    input  wire [7:0]  SECOND_CHANNEL_PORT,
    input  wire        CONFIG_WRITE_STROBE_N,
    input  wire        INTERLEAVE_SELECT,
    // Clock pin and loop
    input  wire        PLL_ENABLE_PIN,
    input  wire        CLOCK_PIN_I,
    output wire        CLOCK_PIN_O,
    output wire        CLOCK_PIN_OE,
    output wire        LOCK_FLAG,
    // Latched samples
    output reg  [7:0]  SAMPLE_A,
    output reg  [7:0]  SAMPLE_B,
    output reg         SAMPLE_VALID,
    // Applied settings
    output reg         POWER_DOWN,
    output reg         STANDBY,
    output reg  [1:0]  INTERP_MODE,
    output reg  [3:0]  GAIN_TRIM,
    output reg  [4:0]  GAIN_STEPS
);

    // ************************************************************
    // Conversion clock
    // ************************************************************
    reg  [7:0] div_cnt_q;
    reg        div_clk_q;
    reg        conv_prev_q;
    wire       conv_level;
    wire       conv_rise;
    wire       conv_fall;

    // Device drives the pin only while its loop is off
    assign CLOCK_PIN_OE = ~PLL_ENABLE_PIN;
    assign CLOCK_PIN_O  = div_clk_q;
    assign conv_level   = PLL_ENABLE_PIN ? CLOCK_PIN_I : div_clk_q;
    assign conv_rise    = conv_level & ~conv_prev_q;
    assign conv_fall    = ~conv_level & conv_prev_q;

    // The divided clock keeps running through control writes
    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            div_cnt_q   <= 8'h00;
            div_clk_q   <= 1'b0;
            conv_prev_q <= 1'b0;
        end else begin
            conv_prev_q <= conv_level;
            if (div_cnt_q == HALF_DIV[7:0] - 8'h01) begin
                div_cnt_q <= 8'h00;
                div_clk_q <= ~div_clk_q;
            end else begin
                div_cnt_q <= div_cnt_q + 8'h01;
            end
        end
    end

    ddimc_lock_det #(
        .EDGES   (LOCK_EDGES),
        .TIMEOUT (LOCK_TIMEOUT)
    ) u_lock (
        .clk      (CLK),
        .rst      (RST),
        .enable   (PLL_ENABLE_PIN),
        .ref_edge (conv_rise & PLL_ENABLE_PIN),
        .locked_q (LOCK_FLAG)
    );

    // ************************************************************
    // Control word capture and staging
    // ************************************************************
    reg        strobe_prev_q;
    reg  [7:0] staged_q;
    reg        pending_q;
    reg  [7:0] word_q;
    wire       strobe_fall;

    assign strobe_fall = strobe_prev_q & ~CONFIG_WRITE_STROBE_N;

    // A word taken in the cycle it would be applied stays pending
    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            strobe_prev_q <= 1'b1;
            staged_q      <= `DDIMC_CW_RESET;
            pending_q     <= 1'b0;
            word_q        <= `DDIMC_CW_RESET;
        end else begin
            strobe_prev_q <= CONFIG_WRITE_STROBE_N;
            if (strobe_fall) begin
                staged_q  <= FIRST_CHANNEL_PORT;
                pending_q <= 1'b1;
            end else if (pending_q && conv_rise) begin
                word_q    <= staged_q;
                pending_q <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Decode of the applied word
    // ************************************************************
    reg        pd_d;
    reg        sb_d;
    reg  [1:0] mode_d;
    reg  [3:0] gain_d;
    reg  [4:0] steps_d;

    always @* begin
        pd_d = word_q[`DDIMC_CW_POWER_DOWN_BIT];
        sb_d = ~pd_d & ~word_q[`DDIMC_CW_CONV_ENABLE_BIT];
        if (word_q[`DDIMC_CW_SECOND_FILT_BIT]) begin
            // The forbidden bit 5 without bit 4 falls back to 1x
            mode_d = word_q[`DDIMC_CW_FIRST_FILT_BIT] ?
                     `DDIMC_MODE_4X : `DDIMC_MODE_1X;
        end else begin
            mode_d = word_q[`DDIMC_CW_FIRST_FILT_BIT] ?
                     `DDIMC_MODE_2X : `DDIMC_MODE_1X;
        end
        gain_d = word_q[`DDIMC_CW_GAIN_MSB:`DDIMC_CW_GAIN_LSB];
        // Two's complement steps, except the top code reaches +8
        if (gain_d == `DDIMC_GAIN_TOP_CODE) begin
            steps_d = `DDIMC_GAIN_TOP_STEPS;
        end else begin
            steps_d = {gain_d[3], gain_d};
        end
    end

    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            POWER_DOWN  <= 1'b0;
            STANDBY     <= 1'b0;
            INTERP_MODE <= `DDIMC_MODE_1X;
            GAIN_TRIM   <= `DDIMC_GAIN_RESET;
            GAIN_STEPS  <= 5'h00;
        end else begin
            POWER_DOWN  <= pd_d;
            STANDBY     <= sb_d;
            INTERP_MODE <= mode_d;
            GAIN_TRIM   <= gain_d;
            GAIN_STEPS  <= steps_d;
        end
    end

    // ************************************************************
    // Sample latching
    // ************************************************************
    localparam CHANNELS = 2;

    wire                  run;
    wire [CHANNELS-1:0]   take;
    wire [8*CHANNELS-1:0] source;
    wire [8*CHANNELS-1:0] latched;

    // Samples freeze outside full operation to save toggling
    assign run          = ~POWER_DOWN & ~STANDBY;
    // Channel A on the rising conversion edge, channel B on the falling one
    assign take[0]      = run & conv_rise;
    assign take[1]      = run & conv_fall;
    assign source[7:0]  = FIRST_CHANNEL_PORT;
    // Interleaved: the second sample rides the first port as well
    assign source[15:8] = INTERLEAVE_SELECT ?
                          FIRST_CHANNEL_PORT : SECOND_CHANNEL_PORT;

    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch = ch + 1) begin : g_chan
            reg [7:0] lat_q;

            always @(posedge CLK or posedge RST) begin
                if (RST) begin
                    lat_q <= 8'h00;
                end else if (take[ch]) begin
                    lat_q <= source[8*ch +: 8];
                end
            end

            assign latched[8*ch +: 8] = lat_q;
        end
    endgenerate

    // Valid follows the second channel, so a pair is complete when it shows, save the first valid after leaving power-down or standby
    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            SAMPLE_VALID <= 1'b0;
        end else begin
            SAMPLE_VALID <= take[1];
        end
    end

    // Plain copies of the channel flip-flops
    always @* begin
        SAMPLE_A = latched[7:0];
        SAMPLE_B = latched[15:8];
    end

endmodule // ddimc_top

// file: verification/ddimc_chk.sv
module ddimc_chk (
    // Clock and reset
    input wire       CLK,
    input wire       RST,
    // Watched ports
    input wire [7:0] FIRST_CHANNEL_PORT,
    input wire       CONFIG_WRITE_STROBE_N,
    input wire       PLL_ENABLE_PIN,
    input wire       CLOCK_PIN_OE,
    input wire       LOCK_FLAG,
    input wire [7:0] SAMPLE_A,
    input wire [7:0] SAMPLE_B,
    input wire       SAMPLE_VALID,
    input wire       POWER_DOWN,
    input wire       STANDBY,
    input wire [1:0] INTERP_MODE,
    input wire [3:0] GAIN_TRIM,
    input wire [4:0] GAIN_STEPS
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    sequence s_fall; CONFIG_WRITE_STROBE_N ##1 !CONFIG_WRITE_STROBE_N; endsequence
    sequence s_idle; POWER_DOWN || STANDBY; endsequence
    property p_oe; CLOCK_PIN_OE == !PLL_ENABLE_PIN; endproperty
    a_oe: assert property (p_oe) else $error("pin enable wrong");
    property p_pd; POWER_DOWN |-> !STANDBY; endproperty
    a_pd: assert property (p_pd) else $error("standby in power-down");
    property p_mode; INTERP_MODE != 2'h3; endproperty
    a_mode: assert property (p_mode) else $error("bad mode");
    property p_steps; GAIN_STEPS == ((GAIN_TRIM == 4'h8) ? 5'h08 : {GAIN_TRIM[3], GAIN_TRIM});
    endproperty
    a_steps: assert property (p_steps) else $error("gain steps wrong");
    property p_pulse; SAMPLE_VALID |=> !SAMPLE_VALID; endproperty
    a_pulse: assert property (p_pulse) else $error("valid too long");
    property p_hold; s_idle |=> $stable(SAMPLE_A) && $stable(SAMPLE_B); endproperty
    a_hold: assert property (p_hold) else $error("sample moved idle");
    property p_pd_apply; s_fall ##0 FIRST_CHANNEL_PORT[7] |-> ##[2:40] POWER_DOWN; endproperty
    a_pd_apply: assert property (p_pd_apply) else $error("no power-down");
    property p_run; s_fall ##0 (FIRST_CHANNEL_PORT[7:6] == 2'b01) |->
        ##[2:40] !(POWER_DOWN || STANDBY);
    endproperty
    a_run: assert property (p_run) else $error("not running");
    property p_rst; $fell(RST) |-> !POWER_DOWN && !STANDBY &&
        INTERP_MODE == 2'h0 && GAIN_TRIM == 4'h0;
    endproperty
    a_rst: assert property (p_rst) else $error("bad reset state");
    property p_lock; !PLL_ENABLE_PIN |=> !LOCK_FLAG; endproperty
    a_lock: assert property (p_lock) else $error("lock without loop");
endmodule // ddimc_chk

bind ddimc_top ddimc_chk i_ddimc_chk (
    .CLK(CLK), .RST(RST), .FIRST_CHANNEL_PORT(FIRST_CHANNEL_PORT),
    .CONFIG_WRITE_STROBE_N(CONFIG_WRITE_STROBE_N), .PLL_ENABLE_PIN(PLL_ENABLE_PIN),
    .CLOCK_PIN_OE(CLOCK_PIN_OE), .LOCK_FLAG(LOCK_FLAG), .SAMPLE_A(SAMPLE_A),
    .SAMPLE_B(SAMPLE_B), .SAMPLE_VALID(SAMPLE_VALID), .POWER_DOWN(POWER_DOWN),
    .STANDBY(STANDBY), .INTERP_MODE(INTERP_MODE), .GAIN_TRIM(GAIN_TRIM),
    .GAIN_STEPS(GAIN_STEPS));

// file: verification/ddimc_host_clk.sv
module ddimc_host_clk (
    // Clock
    input wire clk,
    // Loop request and clock pin
    input wire enable,
    output reg pin
);
    timeunit 1ns;
    timeprecision 1ns;
    integer cnt = 0;
    initial pin = 1'b0;
    // Off the loop the pin is not ours: keep it changing so no stale level looks valid
    always @(posedge clk) begin
        cnt <= (cnt == 2) ? 0 : cnt + 1;
        if (!enable || cnt == 2) begin
            pin <= ~pin;
        end
    end
endmodule // ddimc_host_clk

// file: verification/ddimc_top_tb.sv
module ddimc_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    reg        clk = 1'b0;
    reg        rst = 1'b1;
    reg        stb_n = 1'b1;
    reg        ilv = 1'b0;
    reg        pll_en = 1'b0;
    reg  [7:0] pa = 8'h00;
    reg  [7:0] pb = 8'h00;
    wire       pin_i, pin_o, pin_oe, lock, valid, pd, sb;
    wire [7:0] sa, sbd;
    wire [1:0] mode;
    wire [3:0] trim;
    wire [4:0] steps;
    reg  [7:0] q[$];
    integer    n_mismatch = 0;
    integer    n_checks = 0;
    integer    i, t;
    ddimc_top #(.LOCK_EDGES(4)) i_ddimc_top (.CLK(clk), .RST(rst), .FIRST_CHANNEL_PORT(pa),
        .SECOND_CHANNEL_PORT(pb), .CONFIG_WRITE_STROBE_N(stb_n), .INTERLEAVE_SELECT(ilv),
        .PLL_ENABLE_PIN(pll_en), .CLOCK_PIN_I(pin_i), .CLOCK_PIN_O(pin_o), .CLOCK_PIN_OE(pin_oe),
        .LOCK_FLAG(lock), .SAMPLE_A(sa), .SAMPLE_B(sbd), .SAMPLE_VALID(valid), .POWER_DOWN(pd),
        .STANDBY(sb), .INTERP_MODE(mode), .GAIN_TRIM(trim), .GAIN_STEPS(steps));
    ddimc_host_clk i_ddimc_host_clk (.clk(clk), .enable(pll_en), .pin(pin_i));
    initial forever #25 clk = ~clk;
    task cmp(input string what, input [7:0] exp, input [7:0] got);
        n_checks = n_checks + 1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("[FAIL] %s exp %h got %h", what, exp, got);
        end
    endtask
    task wr(input [7:0] w);
        integer s;
        s = (w[3:0] == 4'h8) ? 8 : ((w[3] == 1'b0) ? w[3:0] : w[3:0] - 16);
        @(negedge clk);
        pa = w;
        stb_n = 1'b0;
        @(negedge clk);
        stb_n = 1'b1;
        repeat (40) @(negedge clk);
        cmp("pd", {7'h00, w[7]}, {7'h00, pd});
        cmp("stby", {7'h00, !w[7] && !w[6]}, {7'h00, sb});
        cmp("mode", w[5] ? 8'h02 : {7'h00, w[4]}, {6'h00, mode});
        cmp("trim", {4'h0, w[3:0]}, {4'h0, trim});
        cmp("steps", {3'h0, s[4:0]}, {3'h0, steps});
    endtask
    task smp(input il);
        @(negedge clk);
        ilv = il;
        t = $urandom;
        pa = t[7:0];
        pb = t[15:8];
        q.push_back(pa);
        q.push_back(il ? pa : pb);
        repeat (10) @(negedge clk);
        for (t = 0; t < 20 && valid !== 1'b1; t = t + 1) @(negedge clk);
        cmp("valid", 8'h01, {7'h00, valid});
        cmp("a", q.pop_front(), sa);
        cmp("b", q.pop_front(), sbd);
    endtask
    task print_verdict;
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        t = $urandom(32'h6a84);
        repeat (2) @(negedge clk);
        rst = 1'b0;
        cmp("reset", 8'h00, {pd, sb, mode, trim});
        // Filter enables only as 00, 01, 11: second without first is never written
        for (i = 0; i < 16; i = i + 1) begin
            wr({i[1:0], (i % 3 == 0) ? 2'b00 : ((i % 3 == 1) ? 2'b01 : 2'b11),
                i[3:0]});
        end
        wr(8'h40);
        for (i = 0; i < 8; i = i + 1) smp(i[0]);
        // Loop off: the pin carries the divided clock, one toggle per two cycles
        t = pin_o;
        i = 0;
        repeat (16) begin
            @(negedge clk);
            if (pin_o !== t[0]) begin
                i = i + 1;
            end
            t = pin_o;
        end
        cmp("pin_o", 8'h08, i[7:0]);
        pll_en = 1'b1;
        for (t = 0; t < 200 && lock !== 1'b1; t = t + 1) @(negedge clk);
        cmp("lock", 8'h01, {7'h00, lock});
        cmp("oe", 8'h00, {7'h00, pin_oe});
        smp(1'b1);
        pll_en = 1'b0;
        repeat (2) @(negedge clk);
        cmp("unlock", 8'h00, {7'h00, lock});
        cmp("oe", 8'h01, {7'h00, pin_oe});
        print_verdict;
    end
    initial begin
        #500000;
        n_mismatch = n_mismatch + 1;
        print_verdict;
    end
endmodule // ddimc_top_tb
